// file: rtl/pmcr_top.sv
`timescale 1ns/1ps
`include "pmcr_cfg.svh"

module pmcr_top (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rst_b,
   // AHB-Lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic        hready,
   input  wire logic [31:0] hwdata,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   // Port pins A, B, C, D, E, G, 8 bits each, port A lowest
   input  wire logic [47:0] pin_in,
   output logic      [47:0] pin_out,
   output logic      [47:0] pin_oe,
   output logic             port_c_slew,
   // Logic-array side
   input  wire logic [7:0]  input_capture_cells_all,
   input  wire logic [7:0]  array_load_first,
   input  wire logic [7:0]  array_data_first,
   input  wire logic [7:0]  array_load_second,
   input  wire logic [7:0]  array_data_second,
   output logic      [7:0]  first_group_out_cells_all,
   output logic      [7:0]  second_group_out_cells_all,
   // Flash status
   input  wire logic [7:0]  primary_prot_in,
   input  wire logic [3:0]  boot_prot_in,
   input  wire logic        security_set_in,
   // Scan programming port
   output logic             scan_port_on
);

   // ----------------------------------------
   // Declarations
   // ----------------------------------------
   pmcr_pkg::pmcr_state_t  st_reg;
   pmcr_pkg::pmcr_state_t  st_next;
   pmcr_pkg::pmcr_aphase_t aph_reg;
   pmcr_pkg::pmcr_aphase_t aph_next;
   pmcr_pkg::pmcr_port_t   port_reg  [`PMCR_NPORTS];
   pmcr_pkg::pmcr_port_t   port_next [`PMCR_NPORTS];
   logic [31:0]            hrdata_reg;
   logic [31:0]            hrdata_next;
   logic                   hready_reg;
   logic                   hready_next;
   logic                   hresp_reg;
   logic [47:0]            pin_meta_reg;
   logic [47:0]            pin_sync_reg;
   logic [47:0]            pin_out_reg;
   logic [47:0]            pin_out_next;
   logic [47:0]            pin_oe_reg;
   logic [47:0]            pin_oe_next;
   logic                   slew_reg;
   logic                   slew_next;
   logic [7:0]             cell1_reg;
   logic [7:0]             cell1_next;
   logic [7:0]             cell2_reg;
   logic [7:0]             cell2_next;
   logic [7:0]             mask1_reg;
   logic [7:0]             mask1_next;
   logic [7:0]             mask2_reg;
   logic [7:0]             mask2_next;
   logic                   tport_reg;
   logic                   tport_next;
   logic                   accept;
   logic                   wr_en;
   logic [7:0]             wbyte;
   logic [11:0]            waddr;
   logic [2:0]             wport;
   logic [7:0]             rd_byte;

   // ----------------------------------------
   // Bus address phase and answer timing
   // ----------------------------------------
   // Reads cost one wait state so a read right behind a write sees the new value
   always_comb begin
      accept      = hsel & hready & htrans[1];
      st_next     = st_reg;
      aph_next    = '0;
      hready_next = 1'b1;
      hrdata_next = hrdata_reg;
      case (st_reg)
         pmcr_pkg::PMCR_ST_IDLE: begin
            if (accept) begin
               aph_next.wr   = hwrite;
               aph_next.rd   = ~hwrite;
               aph_next.addr = haddr[`PMCR_ADDR_W-1:0];
               if (!hwrite) begin
                  st_next     = pmcr_pkg::PMCR_ST_RDWAIT;
                  hready_next = 1'b0;
               end
            end
         end
         pmcr_pkg::PMCR_ST_RDWAIT: begin
            // Keep the read address until the answer is registered
            aph_next    = aph_reg;
            hrdata_next = {`PMCR_RDATA_PAD, rd_byte};
            st_next     = pmcr_pkg::PMCR_ST_IDLE;
         end
         default: begin
            st_next = pmcr_pkg::PMCR_ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         st_reg     <= pmcr_pkg::PMCR_ST_IDLE;
         aph_reg    <= '0;
         hready_reg <= 1'b1;
         hrdata_reg <= `PMCR_RST_DATA;
         hresp_reg  <= `PMCR_HRESP_OKAY;
      end else begin
         st_reg     <= st_next;
         aph_reg    <= aph_next;
         hready_reg <= hready_next;
         hrdata_reg <= hrdata_next;
         hresp_reg  <= `PMCR_HRESP_OKAY;
      end
   end

   // ----------------------------------------
   // Read multiplexer
   // ----------------------------------------
   // Unmapped addresses and port D drive read as zero
   always_comb begin
      rd_byte = `PMCR_RST_BYTE;
      if (aph_reg.addr < `PMCR_PORT_LIMIT) begin
         case (aph_reg.addr[3:2])
            `PMCR_SUB_DIN:   rd_byte = pin_sync_reg[aph_reg.addr[6:4]*8 +: 8];  // [R16]
            `PMCR_SUB_DOUT:  rd_byte = port_reg[aph_reg.addr[6:4]].dout;         // [R17]
            `PMCR_SUB_DIR:   rd_byte = port_reg[aph_reg.addr[6:4]].dir;
            `PMCR_SUB_DRIVE: begin
               if (aph_reg.addr[6:4] != `PMCR_PORT_D) begin
                  rd_byte = port_reg[aph_reg.addr[6:4]].drive;
               end
            end
            default: rd_byte = `PMCR_RST_BYTE;
         endcase
      end else begin
         case (aph_reg.addr)
            `PMCR_OFS_OE_A:   rd_byte = pin_oe_reg[7:0];                   // [R5]
            `PMCR_OFS_OE_B:   rd_byte = pin_oe_reg[15:8];                  // [R5]
            `PMCR_OFS_OE_C:   rd_byte = pin_oe_reg[23:16];                 // [R5]
            `PMCR_OFS_INCELL: rd_byte = input_capture_cells_all;           // [R6]
            `PMCR_OFS_OCELL1: rd_byte = cell1_reg;                         // [R7]
            `PMCR_OFS_OCELL2: rd_byte = cell2_reg;                         // [R8]
            `PMCR_OFS_MASK1:  rd_byte = mask1_reg;
            `PMCR_OFS_MASK2:  rd_byte = mask2_reg;
            `PMCR_OFS_PPROT:  rd_byte = primary_prot_in;                   // [R11]
            `PMCR_OFS_BPROT:  rd_byte = {security_set_in, `PMCR_BPROT_PAD,
                                         boot_prot_in};                    // [R12] [R13] [R18]
            `PMCR_OFS_TPORT:  rd_byte = {`PMCR_TPORT_PAD, tport_reg};      // [R18]
            default:          rd_byte = `PMCR_RST_BYTE;
         endcase
      end
   end

   // ----------------------------------------
   // Write data phase decode
   // ----------------------------------------
   assign wr_en = aph_reg.wr;
   assign wbyte = hwdata[7:0];
   assign waddr = aph_reg.addr;
   assign wport = aph_reg.addr[6:4];

   // ----------------------------------------
   // Port configuration registers
   // ----------------------------------------
   genvar gp;
   generate
      for (gp = 0; gp < `PMCR_NPORTS; gp = gp + 1) begin : g_port
         // Next values; read-only data-in ignores writes
         always_comb begin
            port_next[gp] = port_reg[gp];
            if (wr_en && (waddr < `PMCR_PORT_LIMIT) && (wport == 3'(gp))) begin
               case (waddr[3:2])
                  `PMCR_SUB_DOUT: port_next[gp].dout = wbyte;           // [R17]
                  `PMCR_SUB_DIR:  port_next[gp].dir  = wbyte;           // [R1]
                  `PMCR_SUB_DRIVE: begin
                     if (3'(gp) != `PMCR_PORT_D) begin
                        port_next[gp].drive = wbyte;                    // [R3] [R4]
                     end
                  end
                  default: port_next[gp] = port_reg[gp];
               endcase
            end
         end

         always_ff @(posedge clk) begin
            if (!rst_b) begin
               port_reg[gp] <= '0;                                      // [R1]
            end else begin
               port_reg[gp] <= port_next[gp];
            end
         end

         // Pin drivers follow the new configuration at the same edge
         always_comb begin
            if ((3'(gp) == `PMCR_PORT_C) || (3'(gp) == `PMCR_PORT_D)) begin
               pin_oe_next[gp*8 +: 8]  = port_next[gp].dir;             // [R2] [R4]
               pin_out_next[gp*8 +: 8] = port_next[gp].dout;
            end else begin
               // Open drain only pulls low, floats for a one
               pin_oe_next[gp*8 +: 8]  = port_next[gp].dir &
                  (~port_next[gp].drive | ~port_next[gp].dout);         // [R2] [R3]
               pin_out_next[gp*8 +: 8] = port_next[gp].dout &
                  ~port_next[gp].drive;
            end
         end
      end
   endgenerate

   // Slew flag registered with the pins so the output comes from a flop
   assign slew_next = (port_next[`PMCR_PORT_C].drive != `PMCR_RST_BYTE); // [R4]

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         pin_oe_reg  <= '0;                                             // [R5]
         pin_out_reg <= '0;
         slew_reg    <= 1'b0;
      end else begin
         pin_oe_reg  <= pin_oe_next;
         pin_out_reg <= pin_out_next;
         slew_reg    <= slew_next;
      end
   end

   // ----------------------------------------
   // Pin input synchroniser
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         pin_meta_reg <= '0;
         pin_sync_reg <= '0;
      end else begin
         pin_meta_reg <= pin_in;
         pin_sync_reg <= pin_meta_reg;
      end
   end

   // ----------------------------------------
   // Output cells, masks, test port
   // ----------------------------------------
   // Array loads first, host write after so an unmasked host write wins
   always_comb begin
      cell1_next = (cell1_reg & ~array_load_first) | (array_data_first & array_load_first);
      cell2_next = (cell2_reg & ~array_load_second) |
                   (array_data_second & array_load_second);
      mask1_next = mask1_reg;
      mask2_next = mask2_reg;
      tport_next = tport_reg;
      if (wr_en) begin
         case (waddr)
            `PMCR_OFS_OCELL1: cell1_next = (cell1_next & mask1_reg) |
                                          (wbyte & ~mask1_reg);         // [R7] [R9]
            `PMCR_OFS_OCELL2: cell2_next = (cell2_next & mask2_reg) |
                                          (wbyte & ~mask2_reg);         // [R8] [R10]
            `PMCR_OFS_MASK1:  mask1_next = wbyte;
            `PMCR_OFS_MASK2:  mask2_next = wbyte;
            `PMCR_OFS_TPORT:  tport_next = wbyte[0];                    // [R14] [R15] [R18]
            default:          tport_next = tport_reg;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         cell1_reg <= `PMCR_RST_BYTE;
         cell2_reg <= `PMCR_RST_BYTE;
         mask1_reg <= `PMCR_RST_BYTE;                                   // [R9]
         mask2_reg <= `PMCR_RST_BYTE;                                   // [R10]
         tport_reg <= `PMCR_RST_TPORT;
      end else begin
         cell1_reg <= cell1_next;
         cell2_reg <= cell2_next;
         mask1_reg <= mask1_next;
         mask2_reg <= mask2_next;
         tport_reg <= tport_next;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign hrdata                     = hrdata_reg;
   assign hreadyout                  = hready_reg;
   assign hresp                      = hresp_reg;
   assign pin_out                    = pin_out_reg;
   assign pin_oe                     = pin_oe_reg;
   assign port_c_slew                = slew_reg;                        // [R4]
   assign first_group_out_cells_all  = cell1_reg;
   assign second_group_out_cells_all = cell2_reg;
   assign scan_port_on               = tport_reg;                       // [R14] [R15]

endmodule

// file: include/pmcr_cfg.svh
// Notes on behaviour
// R1: Direction bit 0 makes the pin an input (reset); 1 makes it an output.
// R2: Setting a direction bit turns that pin into an output driving its latch.
// R3: Ports A, B, E, G drive bit: 0 push-pull (default), 1 open-drain.
// R4: Port C drive bit: 1 selects slew-rate-limited output, 0 push-pull. Code has one port_c_slew flag, set while any port C drive bit is 1.
// R5: Output-enable status for A, B, C is read-only: 1 driving, 0 tri-stated.
// R6: Input-cell status reads the eight input cells live; writes do nothing.
// R7: Writing the first output-cell register loads its flops; reading returns them.
// R8: Second output-cell register loads and reads back its own eight flops.
// R9: First mask bit 1 blocks host loading of that cell flop; 0 allows it.
// R10: Second mask bit 1 blocks host loading of that second-group cell flop.
// R11: Primary protection register is read-only; bit 1 means sector protected.
// R12: Boot protection bits 3..0 report secondary sector protection; 6..4 unused.
// R13: Boot protection bit 7 reads 1 once the security bit is set.
// R14: Test-port enable bit 0 set to 1 enables the scan programming port.
// R15: Clearing test-port enable bit 0 disables the scan programming port.
// R16: Data-in register returns live pin levels of host-controlled input pins.
// R17: Data-out register holds latched values driven onto host-controlled outputs.
// R18: Unused bits of boot protection and test-port registers read zero.
`ifndef PMCR_CFG_SVH
`define PMCR_CFG_SVH

// ----------------------------------------
// Sizes
// ----------------------------------------
`define PMCR_NPORTS        6
`define PMCR_ADDR_W       12

// ----------------------------------------
// Port indices
// ----------------------------------------
`define PMCR_PORT_A       3'h0
`define PMCR_PORT_B       3'h1
`define PMCR_PORT_C       3'h2
`define PMCR_PORT_D       3'h3
`define PMCR_PORT_E       3'h4
`define PMCR_PORT_G       3'h5

// ----------------------------------------
// Per-port block: port n at n * 0x10
// ----------------------------------------
`define PMCR_PORT_LIMIT   12'h060
`define PMCR_SUB_DIN      2'h0
`define PMCR_SUB_DOUT     2'h1
`define PMCR_SUB_DIR      2'h2
`define PMCR_SUB_DRIVE    2'h3

// ----------------------------------------
// Shared registers
// ----------------------------------------
`define PMCR_OFS_OE_A     12'h100
`define PMCR_OFS_OE_B     12'h104
`define PMCR_OFS_OE_C     12'h108
`define PMCR_OFS_INCELL   12'h10c
`define PMCR_OFS_OCELL1   12'h110
`define PMCR_OFS_OCELL2   12'h114
`define PMCR_OFS_MASK1    12'h118
`define PMCR_OFS_MASK2    12'h11c
`define PMCR_OFS_PPROT    12'h120
`define PMCR_OFS_BPROT    12'h124
`define PMCR_OFS_TPORT    12'h128

// ----------------------------------------
// Reset values and fields
// ----------------------------------------
`define PMCR_RST_BYTE     8'h00
`define PMCR_RST_TPORT    1'b0
`define PMCR_RST_DATA     32'h0000_0000
`define PMCR_BPROT_SEC_W  4
`define PMCR_BPROT_PAD    3'h0
`define PMCR_TPORT_PAD    7'h00
`define PMCR_RDATA_PAD    24'h00_0000
`define PMCR_HRESP_OKAY   1'b0

`endif

// file: include/pmcr_pkg.sv
package pmcr_pkg;

   // Configuration of one I/O port
   typedef struct packed {
      logic [7:0] dir;
      logic [7:0] dout;
      logic [7:0] drive;
   } pmcr_port_t;

   // Captured bus address phase
   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [11:0] addr;
   } pmcr_aphase_t;

   // Bus answer sequencing
   typedef enum logic [0:0] {
      PMCR_ST_IDLE  = 1'b0,
      PMCR_ST_RDWAIT = 1'b1
   } pmcr_state_t;

endpackage

// file: testbench/pmcr_monitor.sv
`timescale 1ns/1ps
`include "pmcr_cfg.svh"
module pmcr_monitor (
   // Clock and reset
   input wire logic        clk,
   input wire logic        rst_b,
   // Register bus
   input wire logic        hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic        hready,
   input wire logic [31:0] hwdata,
   input wire logic [31:0] hrdata,
   input wire logic        hreadyout,
   input wire logic        hresp,
   // Pins, cells and status
   input wire logic [47:0] pin_oe,
   input wire logic [7:0]  array_load_first,
   input wire logic [7:0]  array_data_first,
   input wire logic [7:0]  first_group_out_cells_all,
   input wire logic [7:0]  second_group_out_cells_all,
   input wire logic [3:0]  boot_prot_in,
   input wire logic        security_set_in,
   input wire logic        scan_port_on
);
   logic        wr_pend_reg;
   logic        wr_pend_next;
   logic [11:0] wr_addr_reg;
   logic [11:0] wr_addr_next;
   logic        cell1_wr;
   // Write data only shows one cycle after the address, so keep the address
   always_comb begin
      wr_pend_next = hsel & hready & htrans[1] & hwrite;
      wr_addr_next = haddr[11:0];
   end
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         wr_pend_reg <= 1'b0;
         wr_addr_reg <= 12'h000;
      end else begin
         wr_pend_reg <= wr_pend_next;
         wr_addr_reg <= wr_addr_next;
      end
   end
   assign cell1_wr = wr_pend_reg & (wr_addr_reg == `PMCR_OFS_OCELL1);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);
   // Read request and its one-wait answer
   sequence s_rd_taken;
      hsel && hready && htrans[1] && !hwrite;
   endsequence
   sequence s_rd_answer;
      !hreadyout ##1 hreadyout;
   endsequence
   a_reset_clears: assert property (disable iff (1'b0) !rst_b |=> hreadyout &&
      pin_oe == 48'h0 && scan_port_on == 1'b0 && first_group_out_cells_all == 8'h00 &&
      second_group_out_cells_all == 8'h00) else $error("outputs not cleared by reset");
   a_read_one_wait: assert property (s_rd_taken |=> s_rd_answer)
      else $error("read answer timing wrong");
   a_write_no_wait: assert property (hsel && hready && htrans[1] && hwrite |=> hreadyout)
      else $error("write data phase stalled");
   a_resp_always_okay: assert property (hresp == 1'b0)
      else $error("error response seen");
   a_rdata_upper_zero: assert property (hrdata[31:8] == 24'h0)
      else $error("read data upper bits set");
   a_scan_port_follows: assert property (
      wr_pend_reg && wr_addr_reg == `PMCR_OFS_TPORT |=> scan_port_on == $past(hwdata[0]))
      else $error("scan port enable not loaded");
   a_cells_hold_idle: assert property (
      !cell1_wr && array_load_first == 8'h00 |=> $stable(first_group_out_cells_all))
      else $error("first cells changed without a load");
   a_array_load_acts: assert property (!cell1_wr && array_load_first != 8'h00 |=>
      ((first_group_out_cells_all ^ $past(array_data_first)) & $past(array_load_first)) == 8'h00)
      else $error("array load lost");
   a_boot_prot_read: assert property ((s_rd_taken and haddr[11:0] == `PMCR_OFS_BPROT)
      ##1 s_rd_answer |-> hrdata[7:0] == {security_set_in, 3'h0, boot_prot_in})
      else $error("boot protection read wrong");
endmodule

bind pmcr_top pmcr_monitor i_mon (.clk, .rst_b, .hsel, .haddr, .htrans, .hwrite, .hready,
   .hwdata, .hrdata, .hreadyout, .hresp, .pin_oe, .array_load_first, .array_data_first,
   .first_group_out_cells_all, .second_group_out_cells_all, .boot_prot_in, .security_set_in,
   .scan_port_on);

// file: testbench/pmcr_host.sv
`timescale 1ns/1ps
module pmcr_host (
   // Clock
   input wire logic        clk,
   // Bus toward the device
   output logic            hsel,
   output logic     [31:0] haddr,
   output logic     [1:0]  htrans,
   output logic            hwrite,
   output logic     [2:0]  hsize,
   output logic     [31:0] hwdata,
   input wire logic        hready,
   input wire logic [31:0] hrdata
);
   // Idle bus from time zero
   initial begin
      hsel = 1'b1;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
   end
   // Bounded wait; a dead slave must not hang the run
   task automatic wait_rdy(output bit ok);
      ok = 1'b0;
      for (int n = 0; n < 20 && !ok; n++) begin
         @(posedge clk);
         ok = hready;
      end
   endtask
   // One single word transfer, signals changed only just after an edge
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] wd,
                       output logic [31:0] rdv, output bit ok);
      bit ok2;
      @(posedge clk);
      htrans <= 2'h2;
      haddr <= {20'h0, a};
      hwrite <= w;
      wait_rdy(ok);
      htrans <= 2'h0;
      hwdata <= wd;
      wait_rdy(ok2);
      ok = ok & ok2;
      rdv = hrdata;
   endtask
endmodule

// file: testbench/port_macrocell_control_regs_bench.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin n_fail++; \
   $display("unexpected %s expected %h seen %h", nm, e, g); end end
module port_macrocell_control_regs_bench;
   logic        clk, rst_b, hsel, hwrite, hreadyout, hresp, port_c_slew, scan_port_on;
   logic        security_set_in;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [3:0]  boot_prot_in;
   logic [7:0]  input_capture_cells_all, array_load_first, array_data_first;
   logic [7:0]  array_load_second, array_data_second, primary_prot_in;
   logic [7:0]  first_group_out_cells_all, second_group_out_cells_all;
   logic [31:0] haddr, hwdata, hrdata;
   logic [47:0] pin_in, pin_out, pin_oe;
   int          n_fail, check_count;
   pmcr_top i_dut (.clk, .rst_b, .hsel, .haddr, .htrans, .hwrite, .hsize, .hready(hreadyout),
      .hwdata, .hrdata, .hreadyout, .hresp, .pin_in, .pin_out, .pin_oe, .port_c_slew,
      .input_capture_cells_all, .array_load_first, .array_data_first, .array_load_second,
      .array_data_second, .first_group_out_cells_all, .second_group_out_cells_all,
      .primary_prot_in, .boot_prot_in, .security_set_in, .scan_port_on);
   pmcr_host i_host (.clk, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
      .hready(hreadyout), .hrdata);
   // 20 MHz clock
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   task automatic results();
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   // Bus helpers; a timeout counts and ends the run
   task automatic bw(input logic [11:0] a, input logic [7:0] d);
      logic [31:0] r;
      bit ok;
      i_host.xfer(1'b1, a, {24'h0, d}, r, ok);
      if (!ok) begin
         n_fail++;
         results();
      end
   endtask
   task automatic br(input logic [11:0] a, input logic [7:0] e);
      logic [31:0] r;
      bit ok;
      i_host.xfer(1'b0, a, 32'h0, r, ok);
      if (!ok) begin
         n_fail++;
         results();
      end else begin
         `CHK($sformatf("reg %h", a), {24'h0, e}, r)
      end
   endtask
   // Configuration registers idle at zero
   task automatic t_reset_vals();
      br(12'h008, 8'h00);
      br(12'h00c, 8'h00);
      br(12'h02c, 8'h00);
      br(12'h100, 8'h00);
      br(12'h118, 8'h00);
      br(12'h11c, 8'h00);
      br(12'h128, 8'h00);
      `CHK("pin_oe", 48'h0, pin_oe)
   endtask
   // Direction, open drain, slew flag and the read-only enable status
   task automatic t_port_drive();
      bw(12'h008, 8'hff);
      bw(12'h004, 8'ha5);
      @(negedge clk);
      `CHK("oe A", 8'hff, pin_oe[7:0])
      `CHK("out A", 8'ha5, pin_out[7:0])
      bw(12'h00c, 8'h0f);
      @(negedge clk);
      `CHK("oe A", 8'hfa, pin_oe[7:0])
      `CHK("out A", 8'ha0, pin_out[7:0])
      br(12'h100, 8'hfa);
      bw(12'h100, 8'h00);
      br(12'h100, 8'hfa);
      bw(12'h058, 8'h0f);
      @(negedge clk);
      `CHK("oe G", 8'h0f, pin_oe[47:40])
      bw(12'h02c, 8'h01);
      @(negedge clk);
      `CHK("slew", 1'b1, port_c_slew)
      bw(12'h028, 8'h3c);
      br(12'h108, 8'h3c);
      bw(12'h03c, 8'hff);
      br(12'h03c, 8'h00);
   endtask
   // Live inputs; pins pass a two-stage synchroniser first
   task automatic t_inputs();
      pin_in <= 48'h0000_0000_3c00;
      input_capture_cells_all <= 8'h96;
      repeat (3) @(posedge clk);
      br(12'h010, 8'h3c);
      bw(12'h10c, 8'h00);
      br(12'h10c, 8'h96);
   endtask
   // Host loads through the masks, then array loads past them
   task automatic t_cells();
      bw(12'h110, 8'h3c);
      br(12'h110, 8'h3c);
      `CHK("cells 1", 8'h3c, first_group_out_cells_all)
      bw(12'h118, 8'h0f);
      bw(12'h110, 8'hc3);
      br(12'h110, 8'hcc);
      bw(12'h114, 8'h5a);
      bw(12'h11c, 8'hf0);
      bw(12'h114, 8'ha5);
      br(12'h114, 8'h55);
      `CHK("cells 2", 8'h55, second_group_out_cells_all)
      array_load_first <= 8'h81;
      array_data_first <= 8'h01;
      array_load_second <= 8'h81;
      array_data_second <= 8'h81;
      @(posedge clk);
      array_load_first <= 8'h00;
      array_load_second <= 8'h00;
      br(12'h110, 8'h4d);
      br(12'h114, 8'hd5);
   endtask
   // Flash status is read-only and unused bits read zero
   task automatic t_protect();
      primary_prot_in <= 8'h5a;
      boot_prot_in <= 4'h9;
      security_set_in <= 1'b1;
      bw(12'h120, 8'h00);
      br(12'h120, 8'h5a);
      br(12'h124, 8'h89);
      bw(12'h124, 8'h70);
      security_set_in <= 1'b0;
      br(12'h124, 8'h09);
   endtask
   // Scan port on and off; unmapped space reads zero
   task automatic t_scan_port();
      bw(12'h128, 8'hff);
      @(negedge clk);
      `CHK("scan on", 1'b1, scan_port_on)
      br(12'h128, 8'h01);
      bw(12'h128, 8'hfe);
      @(negedge clk);
      `CHK("scan on", 1'b0, scan_port_on)
      bw(12'h200, 8'hff);
      br(12'h200, 8'h00);
   endtask
   // Reset in mid-run clears the loaded state again
   task automatic t_mid_reset();
      @(posedge clk);
      rst_b <= 1'b0;
      repeat (2) @(posedge clk);
      rst_b <= 1'b1;
      @(negedge clk);
      `CHK("oe", 48'h0, pin_oe)
      `CHK("cells 1", 8'h00, first_group_out_cells_all)
      br(12'h008, 8'h00);
   endtask
   // Main sequence
   initial begin
      n_fail = 0;
      check_count = 0;
      rst_b = 1'b0;
      pin_in = 48'h0;
      input_capture_cells_all = 8'h00;
      array_load_first = 8'h00;
      array_data_first = 8'h00;
      array_load_second = 8'h00;
      array_data_second = 8'h00;
      primary_prot_in = 8'h00;
      boot_prot_in = 4'h0;
      security_set_in = 1'b0;
      repeat (12) @(posedge clk);
      rst_b <= 1'b1;
      t_reset_vals();
      t_port_drive();
      t_inputs();
      t_cells();
      t_protect();
      t_scan_port();
      t_mid_reset();
      results();
   end
endmodule
